// *** logic/asp_uart.sv ***
// nine-bit asynchronous serial port with ahb-lite register slave
// Functional notes
// RL1 - full duplex, 8- or 9-bit frame select
// RL2 - data write to transmit, read receive latch
// RL3 - 8-bit: start, eight lsb-first, stop
// RL4 - 9-bit: start, eight, tx_ninth_bit, stop
// RL5 - data buffer write starts transmission
// RL6 - tx_done_flag set at stop bit start
// RL7 - receive only while rx_enable_bit set
// RL8 - 8-bit accept: flag clear, stop checked
// RL9 - rejected frame leaves latch, ninth, flag
// RL10 - overrun keeps first byte, drops rest
// RL11 - 9-bit accept: flag clear, ninth checked
// RL12 - interrupt when either flag set, enabled
// RL13 - flags cleared only by software
// RL14 - receive shifter separate from latch
// RL15 - tx and rx timer overflows halved
// RL16 - rx timer copy reloads on start
// RL17 - software sets reload for twice baud
// RL18 - timer clock from five sources
// RL19 - master marks addresses with ninth one
// RL20 - serial_control bit layout, bit6 reads one
// RL21 - receiver samples near bit middle
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
module asp_uart (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic ext_osc_in,
	input wire logic timer_ext_input,
	output logic serial_port_irq
);
	// register state
	logic [7:0] ctrl_q, ctrl_d; // serial_control
	logic [12:0] bcfg_q; // baud configuration
	logic [7:0] rx_latch_q; // buffered receive register
	// bus data-phase capture
	logic wr_pend_q;
	logic [7:0] wr_idx_q;
	// pin synchronisers
	logic [2:0] rx_sync_q; // [0] first stage only
	logic [2:0] osc_sync_q;
	logic [2:0] t1_sync_q;
	// prescalers
	logic [5:0] pre_q;
	logic [2:0] osc_cnt_q;
	// timers and halving stages
	logic [7:0] tx_tmr_q, rx_tmr_q;
	logic tx_half_q, rx_half_q;
	// transmitter
	asp_pkg::asp_state_e tx_st_q;
	logic [7:0] tx_sh_q;
	logic [3:0] tx_cnt_q;
	logic tx_ninth_q;
	// receiver
	asp_pkg::asp_state_e rx_st_q;
	logic [7:0] rx_sh_q;
	logic [3:0] rx_cnt_q;
	logic rx_ninth_q;

	// address decode, taken in the address phase
	wire addr_ok = hsel & htrans[1] & hready;
	wire [7:0] addr_idx = haddr[9:2];
	wire addr_wr = addr_ok & hwrite;
	wire addr_rd = addr_ok & ~hwrite;

	// write strobes in the data phase
	wire wr_ctrl = wr_pend_q & (wr_idx_q == asp_pkg::IDX_SERIAL_CONTROL);
	wire wr_data = wr_pend_q & (wr_idx_q == asp_pkg::IDX_SERIAL_DATA_BUFFER);
	wire wr_bcfg = wr_pend_q & (wr_idx_q == asp_pkg::IDX_BAUD_CONFIG);

	// configuration fields
	wire mode9 = ctrl_q[asp_pkg::SC_FRAME_LENGTH_SELECT]; // RL1
	wire filt_en = ctrl_q[asp_pkg::SC_MULTIPROC_FILTER_ENABLE];
	wire rx_en = ctrl_q[asp_pkg::SC_RX_ENABLE_BIT];
	wire [7:0] reload = bcfg_q[asp_pkg::BC_RELOAD_LSB +: 8];
	wire tmr_run = bcfg_q[asp_pkg::BC_TIMER_RUN];
	wire [2:0] clk_sel = bcfg_q[asp_pkg::BC_CLK_SEL_LSB +: 3];
	wire irq_en = bcfg_q[asp_pkg::BC_IRQ_ENABLE];

	// read mux; serial_control bit 6 always reads one
	wire [7:0] ctrl_rd = ctrl_q | asp_pkg::SC_RESET; // RL20
	wire [31:0] rd_mux =
		(addr_idx == asp_pkg::IDX_SERIAL_CONTROL) ? {24'h000000, ctrl_rd} :
		(addr_idx == asp_pkg::IDX_SERIAL_DATA_BUFFER) ? {24'h000000, rx_latch_q} : // RL2
		(addr_idx == asp_pkg::IDX_BAUD_CONFIG) ? {19'h00000, bcfg_q} :
		(addr_idx == asp_pkg::IDX_BAUD_TIMER_LOW) ? {24'h000000, tx_tmr_q} :
		32'h00000000; // unmapped reads as zero

	// ahb-lite slave: zero wait states, always okay
	always_ff @(posedge clk) begin
		if (srst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= addr_wr;
			wr_idx_q <= addr_idx;
			// read data registered so it stands in the data phase
			if (addr_rd) begin
				hrdata <= rd_mux;
			end
		end
	end

	// baud configuration register, software only
	always_ff @(posedge clk) begin
		if (srst) begin
			bcfg_q <= asp_pkg::BC_RESET;
		end else if (wr_bcfg) begin
			bcfg_q <= hwdata[12:0];
		end
	end

	// pin synchronisers, third stage only feeds edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_sync_q <= 3'h7; // idle line is high
			osc_sync_q <= 3'h0;
			t1_sync_q <= 3'h0;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], serial_in_pin};
			osc_sync_q <= {osc_sync_q[1:0], ext_osc_in};
			t1_sync_q <= {t1_sync_q[1:0], timer_ext_input};
		end
	end
	wire rxd = rx_sync_q[1];
	wire rx_fall = rx_sync_q[2] & ~rx_sync_q[1];
	wire osc_rise = osc_sync_q[1] & ~osc_sync_q[2];
	wire t1_rise = t1_sync_q[1] & ~t1_sync_q[2];

	// core clock prescaler and external oscillator divide by eight
	always_ff @(posedge clk) begin
		if (srst) begin
			pre_q <= 6'h00;
			osc_cnt_q <= 3'h0;
		end else begin
			pre_q <= (pre_q == asp_pkg::PRESCALE_LAST) ? 6'h00 : pre_q + 6'h01;
			if (osc_rise) begin
				osc_cnt_q <= osc_cnt_q + 3'h1;
			end
		end
	end
	wire tick4 = (pre_q[1:0] == 2'h3);
	wire tick12 = (pre_q == 6'h0B) | (pre_q == 6'h17) | (pre_q == 6'h23) | (pre_q == 6'h2F);
	wire tick48 = (pre_q == asp_pkg::PRESCALE_LAST);
	wire tick_osc = osc_rise & (osc_cnt_q == asp_pkg::EXT_OSC_LAST);

	// timer clock source select
	wire tmr_tick = tmr_run & ( // RL18
		(clk_sel == asp_pkg::CLK_SEL_DIV4) ? tick4 :
		(clk_sel == asp_pkg::CLK_SEL_DIV12) ? tick12 :
		(clk_sel == asp_pkg::CLK_SEL_DIV48) ? tick48 :
		(clk_sel == asp_pkg::CLK_SEL_EXT_OSC) ? tick_osc :
		(clk_sel == asp_pkg::CLK_SEL_EXT_INPUT) ? t1_rise : 1'b0);

	// overflow events; rate is tick / (256 - reload), software picks twice baud
	wire tx_ovf = tmr_tick & (tx_tmr_q == asp_pkg::TIMER_TOP); // RL17
	wire rx_ovf = tmr_tick & (rx_tmr_q == asp_pkg::TIMER_TOP);
	wire rx_start_det = (rx_st_q == asp_pkg::ST_IDLE) & rx_en & rx_fall;
	// halved overflow streams give one bit time each
	wire tx_bit = tx_ovf & tx_half_q; // RL15
	wire rx_smp = rx_ovf & ~rx_half_q; // RL21

	// transmit timer, auto-reload
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_tmr_q <= 8'h00;
			tx_half_q <= 1'b0;
		end else if (tmr_tick) begin
			tx_tmr_q <= tx_ovf ? reload : tx_tmr_q + 8'h01;
			if (tx_ovf) begin
				tx_half_q <= ~tx_half_q; // RL15
			end
		end
	end

	// hidden receive timer copy, restarted by the start edge
	// first overflow after restart lands half a bit in, so samples sit mid-bit
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_tmr_q <= 8'h00;
			rx_half_q <= 1'b0;
		end else if (rx_start_det) begin
			rx_tmr_q <= reload; // RL16
			rx_half_q <= 1'b0;
		end else if (tmr_tick) begin
			rx_tmr_q <= rx_ovf ? reload : rx_tmr_q + 8'h01; // RL16
			if (rx_ovf) begin
				rx_half_q <= ~rx_half_q; // RL15
			end
		end
	end

	// transmit frame sequencer; a write while busy is dropped
	wire tx_load = wr_data & (tx_st_q == asp_pkg::ST_IDLE);
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_st_q <= asp_pkg::ST_IDLE;
			tx_sh_q <= 8'h00;
			tx_cnt_q <= 4'h0;
			tx_ninth_q <= 1'b0;
			serial_out_pin <= 1'b1;
		end else if (tx_load) begin
			tx_sh_q <= hwdata[7:0]; // RL5
			tx_ninth_q <= mode9; // RL4
			tx_st_q <= asp_pkg::ST_START;
		end else if (tx_bit) begin
			unique case (tx_st_q)
				asp_pkg::ST_IDLE: begin
					serial_out_pin <= 1'b1;
				end
				asp_pkg::ST_START: begin
					serial_out_pin <= 1'b0; // RL3
					tx_cnt_q <= 4'h0;
					tx_st_q <= asp_pkg::ST_DATA;
				end
				asp_pkg::ST_DATA: begin
					// lsb first
					serial_out_pin <= tx_sh_q[0]; // RL3
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					tx_cnt_q <= tx_cnt_q + 4'h1;
					if (tx_cnt_q == asp_pkg::DATA_BITS - 4'h1) begin
						tx_st_q <= tx_ninth_q ? asp_pkg::ST_NINTH : asp_pkg::ST_STOP;
					end
				end
				asp_pkg::ST_NINTH: begin
					serial_out_pin <= ctrl_q[asp_pkg::SC_TX_NINTH_BIT]; // RL4
					tx_st_q <= asp_pkg::ST_STOP;
				end
				asp_pkg::ST_STOP: begin
					serial_out_pin <= 1'b1;
					tx_st_q <= asp_pkg::ST_IDLE;
				end
				default: begin
					tx_st_q <= asp_pkg::ST_IDLE;
				end
			endcase
		end
	end
	// the last data/ninth bit ends one bit time after it is driven; flag at stop start
	wire tx_stop_begin = tx_bit & (tx_st_q == asp_pkg::ST_STOP); // RL6

	// receive frame sequencer, shift register apart from the latch
	wire rx_stop_smp = rx_smp & (rx_st_q == asp_pkg::ST_STOP);
	wire rx_bit9 = mode9 ? rx_ninth_q : rxd; // RL11
	wire rx_accept = rx_stop_smp & ~ctrl_q[asp_pkg::SC_RX_DONE_FLAG] & (~filt_en | rx_bit9); // RL8
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_st_q <= asp_pkg::ST_IDLE;
			rx_sh_q <= 8'h00;
			rx_cnt_q <= 4'h0;
			rx_ninth_q <= 1'b0;
		end else if (rx_start_det) begin
			rx_st_q <= asp_pkg::ST_START; // RL7
		end else if (rx_smp) begin
			unique case (rx_st_q)
				asp_pkg::ST_IDLE: begin
					rx_cnt_q <= 4'h0;
				end
				asp_pkg::ST_START: begin
					// a high line at mid start bit is a glitch
					rx_st_q <= rxd ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
					rx_cnt_q <= 4'h0;
				end
				asp_pkg::ST_DATA: begin
					rx_sh_q <= {rxd, rx_sh_q[7:1]}; // RL14
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q == asp_pkg::DATA_BITS - 4'h1) begin
						rx_st_q <= mode9 ? asp_pkg::ST_NINTH : asp_pkg::ST_STOP;
					end
				end
				asp_pkg::ST_NINTH: begin
					rx_ninth_q <= rxd; // RL11
					rx_st_q <= asp_pkg::ST_STOP;
				end
				asp_pkg::ST_STOP: begin
					rx_st_q <= asp_pkg::ST_IDLE;
				end
				default: begin
					rx_st_q <= asp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// receive latch loads only on accepted frames
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_latch_q <= asp_pkg::DATA_RESET;
		end else if (rx_accept) begin
			rx_latch_q <= rx_sh_q; // RL10
		end
	end

	// serial_control next value: software write, then hardware sets win
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = hwdata[7:0] | asp_pkg::SC_RESET; // RL20
		end
		if (rx_accept) begin
			ctrl_d[asp_pkg::SC_RX_NINTH_BIT] = rx_bit9; // RL8
			ctrl_d[asp_pkg::SC_RX_DONE_FLAG] = 1'b1; // RL11
		end
		if (tx_stop_begin) begin
			ctrl_d[asp_pkg::SC_TX_DONE_FLAG] = 1'b1; // RL6
		end
	end
	// rejected frames change nothing above; no vector-time clear exists
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= asp_pkg::SC_RESET;
		end else begin
			ctrl_q <= ctrl_d; // RL9 RL13
		end
	end

	// interrupt request while either flag stands and enabled
	always_ff @(posedge clk) begin
		if (srst) begin
			serial_port_irq <= 1'b0;
		end else begin
			serial_port_irq <= irq_en & (ctrl_q[asp_pkg::SC_TX_DONE_FLAG] | ctrl_q[asp_pkg::SC_RX_DONE_FLAG]); // RL12
		end
	end

	// unused bus inputs kept visible for lint
	wire unused_ok = &{1'b0, hsize, haddr[31:10], haddr[1:0], hwdata[31:13]};
endmodule : asp_uart

// *** include/asp_pkg.sv ***
// constants shared by the nine-bit asynchronous serial port
package asp_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
	localparam logic [7:0] IDX_SERIAL_DATA_BUFFER = 8'h99;
	localparam logic [7:0] IDX_BAUD_CONFIG = 8'h9A;
	localparam logic [7:0] IDX_BAUD_TIMER_LOW = 8'h9B;
	// serial_control field positions
	localparam int SC_FRAME_LENGTH_SELECT = 7;
	localparam int SC_READS_ONE = 6;
	localparam int SC_MULTIPROC_FILTER_ENABLE = 5;
	localparam int SC_RX_ENABLE_BIT = 4;
	localparam int SC_TX_NINTH_BIT = 3;
	localparam int SC_RX_NINTH_BIT = 2;
	localparam int SC_TX_DONE_FLAG = 1;
	localparam int SC_RX_DONE_FLAG = 0;
	localparam logic [7:0] SC_RESET = 8'h40;
	// baud_config field positions, then the data buffer reset value
	localparam int BC_RELOAD_LSB = 0;
	localparam int BC_TIMER_RUN = 8;
	localparam int BC_CLK_SEL_LSB = 9;
	localparam int BC_IRQ_ENABLE = 12;
	localparam logic [12:0] BC_RESET = 13'h0000;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// baud timer clock sources
	localparam logic [2:0] CLK_SEL_DIV4 = 3'h0;
	localparam logic [2:0] CLK_SEL_DIV12 = 3'h1;
	localparam logic [2:0] CLK_SEL_DIV48 = 3'h2;
	localparam logic [2:0] CLK_SEL_EXT_OSC = 3'h3;
	localparam logic [2:0] CLK_SEL_EXT_INPUT = 3'h4;
	// prescaler and timer terminal counts, data bit count
	localparam logic [5:0] PRESCALE_LAST = 6'h2F;
	localparam logic [2:0] EXT_OSC_LAST = 3'h7;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [7:0] TIMER_TOP = 8'hFF;
	// frame states, shared by both directions
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_NINTH = 3'b011,
		ST_STOP = 3'b100
	} asp_state_e;
endpackage : asp_pkg

// *** tb/asp_uart_assertions.sv ***
// port-level assertions for the nine-bit serial port
module asp_uart_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic serial_out_pin,
	input wire logic serial_port_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire rd = hsel && htrans[1] && hready && !hwrite; // read address phase
	wire sc = haddr[9:2] == asp_pkg::IDX_SERIAL_CONTROL; // control hit
	logic wr_q; // write data phase
	logic [7:0] idx_q; // index seen in the last cycle
	logic ien_q; // shadow of the irq enable
	// shadow the enable from bus writes, since it is not a port
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_q <= 1'b0;
			idx_q <= 8'h00;
			ien_q <= 1'b0;
		end else begin
			wr_q <= hsel && htrans[1] && hready && hwrite;
			idx_q <= haddr[9:2];
			if (wr_q && idx_q == asp_pkg::IDX_BAUD_CONFIG)
				ien_q <= hwdata[12];
		end
	end
	// software write that clears both done flags
	wire clr = wr_q && idx_q == asp_pkg::IDX_SERIAL_CONTROL && hwdata[1:0] == 2'h0;
	a_reset_idle: assert property ($fell(srst) |-> serial_out_pin && !serial_port_irq)
		else $error("line or irq busy after reset");
	a_zero_wait: assert property (hsel && htrans[1] && hready |=> hreadyout)
		else $error("wait state inserted");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_ctrl_layout: assert property (rd && sc |=> hrdata[31:8] == 24'h000000 && hrdata[6])
		else $error("control read bad");
	a_read_upper: assert property (rd |=> hrdata[31:13] == 19'h0)
		else $error("upper read bits set");
	a_read_stands: assert property (!rd |=> $stable(hrdata))
		else $error("read data moved");
	a_irq_enabled: assert property (serial_port_irq |-> ien_q || $past(ien_q))
		else $error("irq while disabled");
	a_irq_clear: assert property (clr |-> ##2 !serial_port_irq)
		else $error("irq kept after clear");
	a_bit_min: assert property ($fell(serial_out_pin) |=> !serial_out_pin [*7])
		else $error("start bit too short");
	a_frame_ends: assert property ($fell(serial_out_pin) |-> ##[1:200] serial_out_pin)
		else $error("line stuck low");
	c_irq: cover property ($rose(serial_port_irq));
	c_frame: cover property ($fell(serial_out_pin));
	c_ctrl_read: cover property (rd && sc);
endmodule : asp_uart_assertions
bind asp_uart asp_uart_assertions i_chk (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .serial_out_pin, .serial_port_irq);

// *** tb/asp_remote.sv ***
// remote transceiver model: drives frames in, decodes frames out
module asp_remote (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int bt = 16; // clocks per bit, set by the bench per timer setup
	int nb = 9; // bits after start to decode, set per mode
	int nfr = 0; // frames decoded so far
	logic [10:0] got; // last frame, start bit at bit 0
	initial line_out = 1'b1; // idle high
	// send bits lsb first; the frame word carries start, data, ninth, stop
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			line_out <= f[i];
			repeat (bt - 1) @(posedge clk);
		end
		@(posedge clk);
		line_out <= 1'b1;
	endtask : send
	// sample mid-bit from the falling edge; back-to-back frames not handled
	always begin
		@(negedge line_in);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i <= nb; i++) begin
			got[i] = line_in;
			repeat (bt) @(posedge clk);
		end
		nfr++;
	end
endmodule : asp_remote

// *** tb/async_serial_port_nine_bit_bench.sv ***
// self-checking bench for the nine-bit serial port
module async_serial_port_nine_bit_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SC = {22'h0, asp_pkg::IDX_SERIAL_CONTROL, 2'h0}; // control
	localparam logic [31:0] DB = {22'h0, asp_pkg::IDX_SERIAL_DATA_BUFFER, 2'h0}; // data
	localparam logic [31:0] BC = {22'h0, asp_pkg::IDX_BAUD_CONFIG, 2'h0}; // baud
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rv;
	logic hreadyout, hresp, rx_line, tx_line, irq;
	int fails = 0;
	int checks = 0;
	logic ext_t = 1'b0; // external timer source, one rising edge per two cycles
	// 100 MHz clock
	always #5 clk = ~clk;
	// free-running source for the oscillator and external timer inputs
	always @(posedge clk) ext_t <= ~ext_t;
	asp_uart i_dut (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .serial_in_pin(rx_line),
		.serial_out_pin(tx_line), .ext_osc_in(ext_t), .timer_ext_input(ext_t), .serial_port_irq(irq));
	asp_remote i_rem (.clk, .line_in(tx_line), .line_out(rx_line));
	task automatic end_of_test;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// a wait ran out
	task automatic hang;
		fails++;
		end_of_test();
	endtask : hang
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("ERROR %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask : chk
	// wait for hready at a rising edge, bounded
	task automatic wait_rdy;
		int k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50)
			hang();
	endtask : wait_rdy
	// one single transfer; leading edge leaves an idle cycle between transfers
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rv = hrdata;
	endtask : bus
	// reset values, constant bit six, unmapped read
	task automatic t_regs;
		bus(0, SC, 0);
		chk(rv, 32'h40);
		bus(1, SC, 32'hFF);
		bus(0, SC, 0);
		chk(rv, 32'hFF);
		bus(1, SC, 0);
		bus(0, SC, 0);
		chk(rv, 32'h40);
		bus(0, DB, 0);
		chk(rv, 32'h0);
		bus(0, 32'h0, 0);
		chk(rv, 32'h0);
	endtask : t_regs
	// send one character, judge decoded line, flag and irq
	task automatic t_tx(input logic [7:0] sc, input logic [7:0] d, input logic [10:0] ef, input int nb);
		int n0 = i_rem.nfr;
		int k = 0;
		i_rem.nb = nb;
		bus(1, SC, 32'(sc));
		bus(1, DB, 32'(d));
		while (i_rem.nfr == n0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 3000)
			hang();
		chk(32'(i_rem.got) & ~(32'hFFFFFFFF << (nb + 1)), 32'(ef));
		bus(0, SC, 0);
		chk(rv, 32'(sc | 8'h42));
		chk(32'(irq), 32'h1);
		bus(1, SC, 32'(sc));
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h0);
	endtask : t_tx
	// drive one character in, judge latch and control register
	task automatic t_rx(input logic [7:0] sc, input logic [10:0] f, input int n,
		input logic [7:0] ed, input logic [7:0] es);
		bus(1, SC, 32'(sc));
		i_rem.send(f, n);
		repeat (8) @(posedge clk);
		bus(0, DB, 0);
		chk(rv, 32'(ed));
		bus(0, SC, 0);
		chk(rv, 32'(es));
	endtask : t_rx
	// retime the link from another timer clock source, then send one character
	task automatic t_clk(input logic [31:0] bc, input int bt);
		bus(1, BC, bc);
		i_rem.bt = bt;
		t_tx(8'h00, 8'h55, {2'b01, 8'h55, 1'b0}, 9);
	endtask : t_clk
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		t_regs();
		bus(1, BC, 32'h11FE);
		t_tx(8'h00, 8'hA5, {2'b01, 8'hA5, 1'b0}, 9);
		t_tx(8'h88, 8'h3C, {2'b11, 8'h3C, 1'b0}, 10);
		t_tx(8'h80, 8'hC3, {2'b10, 8'hC3, 1'b0}, 10);
		t_rx(8'h00, {1'b1, 8'h3C, 1'b0}, 10, 8'h00, 8'h40);
		t_rx(8'h30, {1'b0, 8'h3C, 1'b0}, 10, 8'h00, 8'h70);
		t_rx(8'h10, {1'b1, 8'h3C, 1'b0}, 10, 8'h3C, 8'h55);
		t_rx(8'h11, {1'b1, 8'h55, 1'b0}, 10, 8'h3C, 8'h51);
		t_rx(8'hB0, {2'b10, 8'hA6, 1'b0}, 11, 8'h3C, 8'hF0);
		t_rx(8'hB0, {2'b11, 8'hA6, 1'b0}, 11, 8'hA6, 8'hF5);
		t_rx(8'h90, {2'b10, 8'h5A, 1'b0}, 11, 8'h5A, 8'hD1);
		// divide by 12, reload FE: 48 clocks per bit
		t_clk(32'h13FE, 48);
		// divide by 48, reload FF: 96 clocks per bit
		t_clk(32'h15FF, 96);
		// oscillator over eight, reload FF: 32 clocks per bit
		t_clk(32'h17FF, 32);
		// external input, reload FE: 8 clocks per bit
		t_clk(32'h19FE, 8);
		end_of_test();
	end
endmodule : async_serial_port_nine_bit_bench
